// File: design/two_wire_frame_defines.vh
// Constants shared by the two-wire frame output block.
`ifndef TWO_WIRE_FRAME_DEFINES_VH
`define TWO_WIRE_FRAME_DEFINES_VH

// ==========================================================================
// Frame layout
// ==========================================================================
`define TW_SYNC_BYTE 8'ha5
`define TW_FRAME_BITS 88
`define TW_PAYLOAD_SHORT 7'h40
`define TW_PAYLOAD_LONG 7'h58
`define TW_CRC_BITS 5'h10
`define TW_LAST_FRAME 2'h3

// ==========================================================================
// Checksum
// ==========================================================================
`define TW_CRC_POLY 16'h8005
`define TW_CRC_INIT 16'h0000

// ==========================================================================
// Strap bit positions in the latched configuration
// ==========================================================================
`define TW_STRAP_DECIM_LO 0
`define TW_STRAP_DECIM_HI 1
`define TW_STRAP_SCALE 2
`define TW_STRAP_GAIN_LO 3
`define TW_STRAP_GAIN_HI 4
`define TW_STRAPS_RESET 5'h00

// ==========================================================================
// Decoded settings
// ==========================================================================
`define TW_RATIO_64 10'h040
`define TW_RATIO_128 10'h080
`define TW_RATIO_256 10'h100
`define TW_RATIO_512 10'h200
`define TW_GAIN_1 6'h01
`define TW_GAIN_8 6'h08
`define TW_GAIN_16 6'h10
`define TW_GAIN_32 6'h20

// ==========================================================================
// Timing
// ==========================================================================
`define TW_CLK_MHZ 200
`define TW_WATCH_NS 3600
`define TW_WATCH_CYCLES ((`TW_WATCH_NS * `TW_CLK_MHZ + 999) / 1000)
`define TW_MCLK_PER_DIGITAL_CORE_CLOCK 4
`define TW_SETTLE_PERIODS 3

`endif

// File: design/level_sync.v
// Two-flop synchroniser for a group of independent levels.
`default_nettype none

module level_sync #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // ========================================================================
  // Stages
  // ========================================================================
  // The first stage feeds the second stage only; it may be metastable.
  reg [WIDTH-1:0] stage1_reg;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

// File: design/frame_crc16.v
// Serial CRC-16 generator, generator 0x8005, MSB first.
`default_nettype none
`include "two_wire_frame_defines.vh"

module frame_crc16 (
  input wire clock,
  input wire reset_n,
  input wire start,
  input wire shift_en,
  input wire bit_in,
  output reg [15:0] crc
);

  // ========================================================================
  // One-bit step
  // ========================================================================
  function [15:0] crc_step;
    input [15:0] value;
    input din;
    begin
      if (value[15] ^ din) begin
        crc_step = {value[14:0], 1'b0} ^ `TW_CRC_POLY;
      end else begin
        crc_step = {value[14:0], 1'b0};
      end
    end
  endfunction

  // ========================================================================
  // Register
  // ========================================================================
  // A start restarts from the seed and folds in the first bit at once.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      crc <= `TW_CRC_INIT;
    end else if (start) begin
      crc <= crc_step(`TW_CRC_INIT, bit_in);
    end else if (shift_en) begin
      crc <= crc_step(crc, bit_in);
    end
  end

endmodule

`default_nettype wire

// File: design/two_wire_frame_output.v
// Two-wire frame output: strap latch, output-rate timing, framer and watchdog.
//
// Functional notes
// - Serial clock edges pace all conversion timing.
// - Frames start unprompted on each result set.
// - Data output always driven, idles low; here driven only in two-wire mode, released outside it.
// - Former control pins act as strap inputs.
// - Bitstream outputs disabled, high impedance.
// - Mode sampled on leaving any reset.
// - Only gain, ratio, scale come from straps.
// - Straps latched on mode pin rising edge.
// - Decimation straps decode to 64/128/256/512.
// - Scale strap low half, high full.
// - Gain straps decode to 1/8/16/32.
// - Ratio 64 frames use 16-bit fields.
// - Higher ratios send 104-bit frames.
// - Sync word holds straps, counter, 0xA5.
// - Four frames per set, counter 0..3.
// - Idle low after set; ratio 64 back-to-back.
// - No frames until filter has settled.
// - Conversion starts after twice ratio clocks.
// - Checksum is CRC-16 with 0x8005.
// - Stuck-high serial clock triggers full reset.
`default_nettype none
`include "two_wire_frame_defines.vh"

module two_wire_frame_output (
  input wire clock,
  input wire reset_n,
  input wire sck_pin,
  input wire interface_select_pin,
  input wire decim_sel_lo,
  input wire decim_sel_hi,
  input wire current_scale_sel,
  input wire ch0_amp_sel_lo,
  input wire ch0_amp_sel_hi,
  input wire [23:0] ch0_result,
  input wire [23:0] ch1_result,
  input wire [23:0] ch2_result,
  output reg sdo_out,
  output reg sdo_oe_n,
  output reg [1:0] modulator_bitstream_out,
  output reg [1:0] modulator_bitstream_out_oe_n,
  output reg two_wire_mode,
  output reg [9:0] decimation_ratio,
  output reg current_scale_full,
  output reg [5:0] ch0_gain,
  output reg output_rate_tick,
  output reg [1:0] frame_index_bits,
  output reg frame_active,
  output reg watchdog_reset_pulse
);

  // ========================================================================
  // Local constants
  // ========================================================================
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PAYLOAD = 3'b010;
  localparam [2:0] ST_CHECK = 3'b100;
  localparam integer WATCH_CYCLES = `TW_WATCH_CYCLES;
  localparam integer SETTLE_PERIODS = `TW_SETTLE_PERIODS;
  localparam [11:0] WATCH_LIMIT = WATCH_CYCLES[11:0];
  localparam [2:0] SETTLE_LIMIT = SETTLE_PERIODS[2:0];

  // ========================================================================
  // Decode functions
  // ========================================================================
  function [9:0] ratio_decode;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: ratio_decode = `TW_RATIO_64;
        2'b01: ratio_decode = `TW_RATIO_128;
        2'b10: ratio_decode = `TW_RATIO_256;
        default: ratio_decode = `TW_RATIO_512;
      endcase
    end
  endfunction

  function [5:0] gain_decode;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: gain_decode = `TW_GAIN_1;
        2'b01: gain_decode = `TW_GAIN_8;
        2'b10: gain_decode = `TW_GAIN_16;
        default: gain_decode = `TW_GAIN_32;
      endcase
    end
  endfunction

  // Frame content, left-justified; short frames keep the upper 16 bits of each result.
  function [`TW_FRAME_BITS-1:0] build_frame;
    input [1:0] cnt;
    input [4:0] straps;
    input short_fmt;
    input [23:0] a;
    input [23:0] b;
    input [23:0] c;
    reg [7:0] cfg;
    begin
      cfg = {cnt, straps[`TW_STRAP_DECIM_HI], straps[`TW_STRAP_DECIM_LO], straps[`TW_STRAP_GAIN_HI],
             straps[`TW_STRAP_GAIN_LO], straps[`TW_STRAP_SCALE], 1'b0};
      if (short_fmt) begin
        build_frame = {`TW_SYNC_BYTE, cfg, a[23:8], b[23:8], c[23:8], 24'h000000};
      end else begin
        build_frame = {`TW_SYNC_BYTE, cfg, a, b, c};
      end
    end
  endfunction

  // ========================================================================
  // Input synchronisation
  // ========================================================================
  wire [6:0] pins_sync;
  wire sck_s;
  wire mode_s;
  wire [4:0] straps_s;

  level_sync #(
    .WIDTH(7)
  ) u_pin_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({sck_pin, interface_select_pin, ch0_amp_sel_hi, ch0_amp_sel_lo, current_scale_sel,
               decim_sel_hi, decim_sel_lo}),
    .sync_out(pins_sync)
  );

  assign sck_s = pins_sync[6];
  assign mode_s = pins_sync[5];
  assign straps_s = pins_sync[4:0];

  reg sck_d_reg;
  reg mode_d_reg;
  wire sck_rise;
  wire sck_fall;
  wire mode_rise;

  // The serial clock is the master clock: every tick below follows its edges.
  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  assign mode_rise = mode_s & ~mode_d_reg;

  // ========================================================================
  // Mode and strap latch
  // ========================================================================
  reg init_pending_reg;
  reg [1:0] init_wait_reg;
  reg [4:0] straps_reg;
  reg wd_fire_reg;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_reg <= 1'b0;
      mode_d_reg <= 1'b0;
      init_pending_reg <= 1'b1;
      init_wait_reg <= 2'h0;
      two_wire_mode <= 1'b0;
      straps_reg <= `TW_STRAPS_RESET;
    end else begin
      sck_d_reg <= sck_s;
      mode_d_reg <= mode_s;
      if (wd_fire_reg) begin
        init_pending_reg <= 1'b1;
        init_wait_reg <= 2'h0;
        two_wire_mode <= 1'b0;
        straps_reg <= `TW_STRAPS_RESET;
      end else if (init_pending_reg) begin
        // Reset clears the synchroniser, so wait until the pin levels have passed it.
        if (init_wait_reg != 2'h2) begin
          init_wait_reg <= init_wait_reg + 2'h1;
        end else begin
          init_pending_reg <= 1'b0;
          two_wire_mode <= mode_s;
          if (mode_s) begin
            straps_reg <= straps_s;
          end
        end
      end else if (mode_rise) begin
        straps_reg <= straps_s;
      end
    end
  end

  // Everything else keeps its default; only these three settings follow the straps.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      decimation_ratio <= `TW_RATIO_64;
      current_scale_full <= 1'b0;
      ch0_gain <= `TW_GAIN_1;
    end else begin
      decimation_ratio <= ratio_decode({straps_reg[`TW_STRAP_DECIM_HI],
        straps_reg[`TW_STRAP_DECIM_LO]});
      current_scale_full <= straps_reg[`TW_STRAP_SCALE];
      ch0_gain <= gain_decode({straps_reg[`TW_STRAP_GAIN_HI], straps_reg[`TW_STRAP_GAIN_LO]});
    end
  end

  // ========================================================================
  // Watchdog on a stuck-high serial clock
  // ========================================================================
  // A slow but running clock is fine; only a long high phase resets, which is
  // also how the receiver leaves the mode after pulling the mode pin low.
  reg [11:0] wd_cnt_reg;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wd_cnt_reg <= 12'h000;
      wd_fire_reg <= 1'b0;
    end else begin
      wd_fire_reg <= 1'b0;
      if (!two_wire_mode || !sck_s || wd_fire_reg) begin
        wd_cnt_reg <= 12'h000;
      end else if (sck_rise) begin
        wd_cnt_reg <= 12'h001;
      end else if (wd_cnt_reg != 12'h000) begin
        if (wd_cnt_reg >= WATCH_LIMIT) begin
          wd_fire_reg <= 1'b1;
          wd_cnt_reg <= 12'h000;
        end else begin
          wd_cnt_reg <= wd_cnt_reg + 12'h001;
        end
      end
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_reset_pulse <= 1'b0;
    end else begin
      watchdog_reset_pulse <= wd_fire_reg;
    end
  end

  // ========================================================================
  // Output-rate timing and result capture
  // ========================================================================
  wire running;
  wire [11:0] start_delay;
  wire [11:0] rate_period;
  reg started_reg;
  reg [11:0] mclk_cnt_reg;
  reg [2:0] settle_cnt_reg;
  reg [23:0] res0_reg;
  reg [23:0] res1_reg;
  reg [23:0] res2_reg;
  reg pending_reg;
  reg take_set;

  assign running = two_wire_mode & ~init_pending_reg & ~wd_fire_reg;
  // All channels share one start; no phase offset between them.
  assign start_delay = {1'b0, decimation_ratio, 1'b0};
  assign rate_period = {decimation_ratio, 2'b00};

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      started_reg <= 1'b0;
      mclk_cnt_reg <= 12'h000;
      settle_cnt_reg <= 3'h0;
      output_rate_tick <= 1'b0;
    end else begin
      output_rate_tick <= 1'b0;
      if (!running) begin
        started_reg <= 1'b0;
        mclk_cnt_reg <= 12'h000;
        settle_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
        if (!started_reg) begin
          if (mclk_cnt_reg == start_delay - 12'h001) begin
            started_reg <= 1'b1;
            mclk_cnt_reg <= 12'h000;
          end else begin
            mclk_cnt_reg <= mclk_cnt_reg + 12'h001;
          end
        end else if (mclk_cnt_reg == rate_period - 12'h001) begin
          mclk_cnt_reg <= 12'h000;
          output_rate_tick <= 1'b1;
          if (settle_cnt_reg != SETTLE_LIMIT) begin
            settle_cnt_reg <= settle_cnt_reg + 3'h1;
          end
        end else begin
          mclk_cnt_reg <= mclk_cnt_reg + 12'h001;
        end
      end
    end
  end

  wire result_valid;
  assign result_valid = output_rate_tick & (settle_cnt_reg == SETTLE_LIMIT);

  // A new set arriving as the framer takes the old one is kept: set wins.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg <= 1'b0;
      res0_reg <= 24'h000000;
      res1_reg <= 24'h000000;
      res2_reg <= 24'h000000;
    end else if (!running) begin
      pending_reg <= 1'b0;
    end else begin
      if (result_valid) begin
        pending_reg <= 1'b1;
        res0_reg <= ch0_result;
        res1_reg <= ch1_result;
        res2_reg <= ch2_result;
      end else if (take_set) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Framer
  // ========================================================================
  reg [2:0] state_reg;
  reg [`TW_FRAME_BITS-1:0] shift_reg;
  reg [6:0] bit_cnt_reg;
  reg [15:0] crc_tx_reg;
  reg [23:0] tx0_reg;
  reg [23:0] tx1_reg;
  reg [23:0] tx2_reg;
  reg [1:0] cnt_reg;
  reg crc_start;
  reg crc_shift;
  reg crc_bit;
  reg start_frame;
  reg [1:0] next_cnt;
  reg [23:0] next0;
  reg [23:0] next1;
  reg [23:0] next2;
  reg [`TW_FRAME_BITS-1:0] next_frame;
  wire [15:0] crc_value;
  wire short_fmt;
  wire [6:0] payload_len;
  wire last_crc_bit;

  assign short_fmt = (decimation_ratio == `TW_RATIO_64);
  assign payload_len = short_fmt ? `TW_PAYLOAD_SHORT : `TW_PAYLOAD_LONG;
  assign last_crc_bit = (state_reg == ST_CHECK) && (bit_cnt_reg == {2'b00, `TW_CRC_BITS});

  // Decide on each falling edge whether a new frame begins.
  always @* begin
    start_frame = 1'b0;
    take_set = 1'b0;
    next_cnt = 2'h0;
    next0 = tx0_reg;
    next1 = tx1_reg;
    next2 = tx2_reg;
    if (running && sck_fall) begin
      if (state_reg == ST_IDLE || last_crc_bit) begin
        if (last_crc_bit && cnt_reg != `TW_LAST_FRAME) begin
          start_frame = 1'b1;
          next_cnt = cnt_reg + 2'h1;
        end else if (pending_reg) begin
          // Back-to-back when the next set is already waiting, as at ratio 64.
          start_frame = 1'b1;
          take_set = 1'b1;
          next0 = res0_reg;
          next1 = res1_reg;
          next2 = res2_reg;
        end
      end
    end
    next_frame = build_frame(next_cnt, straps_reg, short_fmt, next0, next1, next2);
    crc_start = start_frame;
    crc_shift = running && sck_fall && (state_reg == ST_PAYLOAD) && (bit_cnt_reg != payload_len);
    crc_bit = start_frame ? next_frame[`TW_FRAME_BITS-1] : shift_reg[`TW_FRAME_BITS-1];
  end

  frame_crc16 u_crc (
    .clock(clock),
    .reset_n(reset_n),
    .start(crc_start),
    .shift_en(crc_shift),
    .bit_in(crc_bit),
    .crc(crc_value)
  );

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= {`TW_FRAME_BITS{1'b0}};
      bit_cnt_reg <= 7'h00;
      crc_tx_reg <= 16'h0000;
      tx0_reg <= 24'h000000;
      tx1_reg <= 24'h000000;
      tx2_reg <= 24'h000000;
      cnt_reg <= 2'h0;
      sdo_out <= 1'b0;
    end else if (!running) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 7'h00;
      cnt_reg <= 2'h0;
      sdo_out <= 1'b0;
    end else if (sck_fall) begin
      // Changing on the falling edge gives the receiver a half period of setup.
      if (start_frame) begin
        state_reg <= ST_PAYLOAD;
        cnt_reg <= next_cnt;
        tx0_reg <= next0;
        tx1_reg <= next1;
        tx2_reg <= next2;
        sdo_out <= next_frame[`TW_FRAME_BITS-1];
        shift_reg <= {next_frame[`TW_FRAME_BITS-2:0], 1'b0};
        bit_cnt_reg <= 7'h01;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sdo_out <= 1'b0;
          end
          ST_PAYLOAD: begin
            if (bit_cnt_reg == payload_len) begin
              state_reg <= ST_CHECK;
              sdo_out <= crc_value[15];
              crc_tx_reg <= {crc_value[14:0], 1'b0};
              bit_cnt_reg <= 7'h01;
            end else begin
              sdo_out <= shift_reg[`TW_FRAME_BITS-1];
              shift_reg <= {shift_reg[`TW_FRAME_BITS-2:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 7'h01;
            end
          end
          ST_CHECK: begin
            if (last_crc_bit) begin
              state_reg <= ST_IDLE;
              sdo_out <= 1'b0;
              bit_cnt_reg <= 7'h00;
            end else begin
              sdo_out <= crc_tx_reg[15];
              crc_tx_reg <= {crc_tx_reg[14:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 7'h01;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            sdo_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Pin drivers and status
  // ========================================================================
  // The serial-register mode is not built here, so outside two-wire mode the
  // data pin is released rather than left to fight another driver.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sdo_oe_n <= 1'b1;
      modulator_bitstream_out <= 2'b00;
      modulator_bitstream_out_oe_n <= 2'b11;
      frame_index_bits <= 2'h0;
      frame_active <= 1'b0;
    end else begin
      sdo_oe_n <= ~two_wire_mode;
      modulator_bitstream_out <= 2'b00;
      modulator_bitstream_out_oe_n <= 2'b11;
      frame_index_bits <= cnt_reg;
      frame_active <= (state_reg != ST_IDLE);
    end
  end

endmodule

`default_nettype wire

// File: test/sck_source.sv
// Receiver-side model: serial clock source with a stuck-high control.
`default_nettype none
module sck_source (
  output logic sck,
  input wire logic hold_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // The clock runs free; holding it high is the only way to force the watchdog.
  initial sck = 1'b0;
  always begin
    #24;
    sck = hold_high ? 1'b1 : ~sck;
  end
endmodule
`default_nettype wire

// File: test/two_wire_frame_output_chk.sv
// Port assertions for the two-wire frame output block.
`default_nettype none
module two_wire_frame_output_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sck_pin,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic [1:0] modulator_bitstream_out_oe_n,
  input wire logic two_wire_mode,
  input wire logic [9:0] decimation_ratio,
  input wire logic [5:0] ch0_gain,
  input wire logic output_rate_tick,
  input wire logic [1:0] frame_index_bits,
  input wire logic frame_active,
  input wire logic watchdog_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] high_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ====
  // Helper
  // Counts cycles with the serial clock high; saturates so a long hold cannot wrap.
  always @(posedge clock or negedge reset_n)
    if (!reset_n) high_reg <= 12'h000;
    else if (!sck_pin) high_reg <= 12'h000;
    else if (high_reg != 12'hfff) high_reg <= high_reg + 12'h001;
  // ====
  // Assertions
  a_sdo_idle_low: assert property (!frame_active && !$past(frame_active) |-> !$past(sdo_out))
    else $error("data high outside a frame");
  a_sdo_driven: assert property (sdo_oe_n == !$past(two_wire_mode))
    else $error("data enable wrong");
  a_bitstream_off: assert property (modulator_bitstream_out_oe_n == 2'h3)
    else $error("bitstream enabled");
  a_ratio_legal: assert property (decimation_ratio inside {10'h040, 10'h080, 10'h100, 10'h200})
    else $error("bad ratio");
  a_gain_legal: assert property (ch0_gain inside {6'h01, 6'h08, 6'h10, 6'h20})
    else $error("bad gain");
  a_tick_spacing: assert property (output_rate_tick |=> !output_rate_tick [*8])
    else $error("ticks too close");
  a_wdog_cause: assert property (watchdog_reset_pulse |-> high_reg > 12'h2bc)
    else $error("watchdog without long high clock");
  a_quiet_mode: assert property (!two_wire_mode && !$past(two_wire_mode) |-> !sdo_out && !frame_active)
    else $error("frames outside mode");
  a_count_step: assert property (frame_active && $past(frame_active) && frame_index_bits != $past(frame_index_bits)
    |-> frame_index_bits == $past(frame_index_bits) + 2'h1)
    else $error("frame counter skipped");
  a_sdo_on_fall: assert property (two_wire_mode && $changed(sdo_out) |-> !$past(sck_pin, 2) || !$past(sck_pin, 3))
    else $error("data changed away from a falling clock");
  c_frame: cover property ($rose(frame_active));
  c_last: cover property (frame_active && frame_index_bits == 2'h3);
  c_tick: cover property (output_rate_tick);
  c_wdog: cover property (watchdog_reset_pulse);
endmodule
`default_nettype wire

// File: test/two_wire_frame_output_tb.sv
// Self-checking bench for the two-wire frame output block.
`default_nettype none
module two_wire_frame_output_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic hold = 1'b0;
  logic mode = 1'b1;
  logic [4:0] s = 5'h00;
  logic [23:0] d0 = 24'h0, d1 = 24'h0, d2 = 24'h0;
  logic sck, sdo_out, sdo_oe_n, two_wire_mode, current_scale_full, output_rate_tick, frame_active, wd_pulse;
  logic [1:0] mbo, mbo_oe_n, frame_index_bits;
  logic [9:0] decimation_ratio;
  logic [5:0] ch0_gain;
  logic [103:0] exp_q[$];
  logic [103:0] got = '0;
  int fail_count = 0, checks_done = 0, rises = 0, nb = 0, frames = 0, gap = 0, ratio = 64, first_at = 0;
  two_wire_frame_output i_two_wire_frame_output (.clock, .reset_n, .sck_pin(sck), .interface_select_pin(mode),
    .decim_sel_lo(s[0]), .decim_sel_hi(s[1]), .current_scale_sel(s[2]), .ch0_amp_sel_lo(s[3]),
    .ch0_amp_sel_hi(s[4]), .ch0_result(d0), .ch1_result(d1), .ch2_result(d2), .sdo_out, .sdo_oe_n,
    .modulator_bitstream_out(mbo), .modulator_bitstream_out_oe_n(mbo_oe_n), .two_wire_mode, .decimation_ratio,
    .current_scale_full, .ch0_gain, .output_rate_tick, .frame_index_bits, .frame_active,
    .watchdog_reset_pulse(wd_pulse));
  sck_source i_sck_source (.sck, .hold_high(hold));
  always #2.5 clock = ~clock;
  // ====
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [103:0] g, input logic [103:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_cfg(input logic [4:0] t);
    check(decimation_ratio, 10'h040 << t[1:0], "ratio");
    check(ch0_gain, (t[4:3] == 2'h0) ? 6'h01 : 6'h04 << t[4:3], "gain");
    check(current_scale_full, t[2], "scale");
  endtask
  // Sync byte, config byte, results (upper 16 bits at ratio 64), then the checksum.
  function automatic logic [103:0] frame_of(input logic [1:0] c);
    logic [87:0] m;
    logic [15:0] crc;
    crc = 16'h0000;
    m = (ratio == 64) ? {24'h0, 8'ha5, c, s[1:0], s[4:3], s[2], 1'b0, d0[23:8], d1[23:8], d2[23:8]}
      : {8'ha5, c, s[1:0], s[4:3], s[2], 1'b0, d0, d1, d2};
    for (int i = (ratio == 64) ? 63 : 87; i >= 0; i--)
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ m[i]) ? 16'h8005 : 16'h0000);
    return {m, crc};
  endfunction
  task automatic restart(input logic [4:0] t);
    reset_n = 1'b0;
    mode = 1'b1;
    s = t;
    ratio = 64 << t[1:0];
    {d0, d1, d2} = 72'({$urandom, $urandom, $urandom});
    tick(3);
    reset_n = 1'b1;
    {rises, nb, frames, gap, first_at} = '0;
    got = '0;
    exp_q.delete();
    tick(4);
  endtask
  task automatic run_frames(input logic [4:0] t);
    restart(t);
    for (int k = 0; k < 8; k++)
      exp_q.push_back(frame_of(k[1:0]));
    for (int k = 0; k < 80000 && frames < 8; k++)
      tick(1);
    check(frames, 8, "frame count");
    check(first_at > 12 * ratio && first_at < 20 * ratio, 1, "first frame time");
    check(gap == 0, ratio == 64, "gap between sets");
    $display("test frames at ratio %0d done", ratio);
  endtask
  // ====
  // Monitor: collects bits on each rising serial clock and compares whole frames.
  always @(posedge sck) begin
    rises++;
    if (frame_active) begin
      if (first_at == 0)
        first_at = rises;
      got = {got[102:0], sdo_out};
      nb++;
      if (nb == ((ratio == 64) ? 80 : 104)) begin
        if (exp_q.size() > 0)
          check(got, exp_q.pop_front(), "frame");
        nb = 0;
        got = '0;
        frames++;
      end
    end else if (frames > 0 && frames % 4 == 0) begin
      gap++;
    end
  end
  // ====
  // Main sequence
  initial begin
    void'($urandom(10658));
    tick(1);
    for (int i = 0; i < 4; i++) begin
      restart({i[1:0], i[0], i[1:0]});
      check({two_wire_mode, sdo_oe_n, mbo, mbo_oe_n}, 6'h23, "mode and enables");
      chk_cfg(s);
      s = ~s;
      tick(6);
      chk_cfg(~s);
      mode = 1'b0;
      tick(6);
      mode = 1'b1;
      tick(6);
      chk_cfg(s);
      $display("test straps %0d done", i);
    end
    run_frames(5'h00);
    run_frames(5'h1d);
    mode = 1'b0;
    for (int k = 0; k < 20000 && frame_active; k++)
      tick(1);
    hold = 1'b1;
    for (int k = 0; k < 1000 && !wd_pulse; k++)
      tick(1);
    check(wd_pulse, 1, "watchdog pulse");
    tick(3);
    check({two_wire_mode, sdo_oe_n, current_scale_full, decimation_ratio, ch0_gain}, {3'h2, 10'h040, 6'h01},
      "defaults");
    hold = 1'b0;
    $display("test watchdog done");
    tally_and_finish();
  end
  initial begin
    #400us;
    fail_count++;
    $display("wrong value at %0t ns: timeout", $time);
    tally_and_finish();
  end
endmodule
bind two_wire_frame_output two_wire_frame_output_chk i_chk (.clock, .reset_n, .sck_pin, .sdo_out, .sdo_oe_n,
  .modulator_bitstream_out_oe_n, .two_wire_mode, .decimation_ratio, .ch0_gain, .output_rate_tick,
  .frame_index_bits, .frame_active, .watchdog_reset_pulse);
`default_nettype wire
